/* hw/cfam_pkg.sv */
// Constants and types of the converter fault and alert manager
package cfam_pkg;
   localparam int          CLK_NS          = 40;
   localparam int          LOCK_WIN_NS     = 1_000_000;
   localparam int          MS_CYCLES       = (LOCK_WIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int          WD_MS           = 100;
   localparam int          RETRY_SCALE     = 100;
   localparam logic [7:0]  A_CTRL          = 8'h00;
   localparam logic [7:0]  A_STATUS        = 8'h04;
   localparam logic [7:0]  A_FLAGS         = 8'h08;
   localparam logic [7:0]  A_ALERT_MASK    = 8'h0C;
   localparam logic [7:0]  A_FAULT_CFG     = 8'h10;
   localparam logic [7:0]  A_READ_IOUT     = 8'h14;
   localparam logic [7:0]  A_READ_FREQ     = 8'h18;
   localparam logic [7:0]  A_READ_TEMP2    = 8'h1C;
   localparam logic [7:0]  A_PEC           = 8'h20;
   localparam logic [7:0]  A_LIMITS        = 8'h24;
   localparam logic [7:0]  A_VOUT          = 8'h28;
   localparam int          CTRL_OP_ON      = 0;
   localparam int          CTRL_SRC_LSB    = 1;
   localparam int          CTRL_RESYNC     = 3;
   localparam int          CTRL_SYNC_LSB   = 4;
   localparam int          CTRL_WD_KICK    = 6;
   localparam int          CFG_RETRY_LSB   = 16;
   localparam int          PEC_CLEAR       = 8;
   localparam logic [2:0]  RETRY_HICCUP    = 3'h7;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
   localparam logic [31:0] MASK_RST        = 32'h0000_0000;
   localparam logic [31:0] FAULT_CFG_RST   = 32'h0000_0000;
   localparam logic [31:0] LIMITS_RST      = 32'h0C00_0F00;
   localparam logic [31:0] VOUT_RST        = 32'h0000_0017;
   localparam logic [7:0]  PEC_POLY        = 8'h07;
   localparam int          NFAULT          = 4;
   localparam int          FAULT_OT        = 0;
   typedef enum logic [1:0] {SYNC_OFF, SYNC_IN, SYNC_OUT, SYNC_RSVD} cfam_sync_t;
   typedef enum logic [1:0] {SRC_PIN, SRC_CMD, SRC_BOTH, SRC_RSVD} cfam_src_t;
endpackage

/* hw/cfam_fault_timer.sv */
// Delay-to-fault qualifier of one fault source
`timescale 1ns/100ps
module cfam_fault_timer (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       ms_tick,
   input  wire logic       detect,
   input  wire logic [7:0] delay_ms,
   output logic            confirmed
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;

   // Restart whenever the detection drops, so only a persisting fault qualifies
   assign cnt_d = !detect ? 8'h00 :
                  (ms_tick && cnt_q != delay_ms) ? cnt_q + 8'h01 : cnt_q;
   assign confirmed = detect && (delay_ms == 8'h00 || cnt_q == delay_ms);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt_q <= 8'h00;
      else cnt_q <= cnt_d;
   end

   AST_PERSIST: assert property (@(posedge hclk) disable iff (!hresetn)
      (confirmed && delay_ms != 8'h00) |-> $past(detect))
      else $error("Fault confirmed without persistence");
endmodule // cfam_fault_timer

/* hw/cfam_top.sv */
// Converter fault, retry, sync, watchdog and alert manager with AHB-Lite registers
// Operation
// - Sync input locks switching only within 1 ms after enable.
// - Later relock only by output off/on toggle or resync command.
// - Sync pin selectable off, input or output; defaults off.
// - Warning sets flag only; fault sets flag and triggers response.
// - Over-temperature fault gives soft-off to nominal off voltage.
// - Other faults give high-impedance, both switches off.
// - Nonzero delay-to-fault: respond only if fault persisted throughout.
// - Nonzero delay-to-retry: wait, recheck, respond again or discard.
// - Nonzero delay-to-fault makes retry delay 100 times it.
// - Retry count zero to six; seven means unlimited hiccup.
// - Watchdog: safe shutdown, reload configuration, restart default.
// - Packet error checking per PMBus.
// - Every fault and warning except warn_in[0] alerts by default; each deselectable.
// - Default: pin alone enables output, OPERATION ignored.
// - Current readback is low-pass filtered.
// - Frequency readback gives switching frequency in kHz.
// - Telemetry uses LINEAR format; voltages follow VOUT_MODE.
// - Second temperature read returns controller die temperature.
// - Over-current compares unfiltered sample against threshold.
// - Enable source: command, pin, or both.
`timescale 1ns/100ps
module cfam_top
   import cfam_pkg::*;
#(
   parameter int MS_CYC     = cfam_pkg::MS_CYCLES,
   parameter int WD_CYC     = cfam_pkg::WD_MS * cfam_pkg::MS_CYCLES,
   parameter int SYNC_DIV   = 10
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        ctrl_pin,
   input  wire logic        sync_in,
   output logic             sync_out,
   output logic             sync_oe,
   output logic             alert_out_pin,
   output logic             alert_out_pin_oe,
   input  wire logic [11:0] iout_sample,
   input  wire logic [11:0] die_temp,
   input  wire logic [2:0]  fault_in,
   input  wire logic [3:0]  warn_in,
   output logic             output_en,
   output logic             soft_off,
   output logic             hiz,
   output logic [15:0]      nominal_off_voltage,
   output logic [15:0]      vout_target,
   output logic [7:0]       vout_mode,
   output logic             mcu_reset
);
   import cfam_pkg::*;

   if (MS_CYC < 2 || WD_CYC < 2 || SYNC_DIV < 1) begin : g_bad_param
      $error("cfam_top: bad parameters");
   end

   typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_WAIT, ST_LATCH} cfam_state_t;

   // Bus address phase capture
   logic        wr_q, rd_q;
   logic [7:0]  addr_q;
   logic        acc;
   assign acc       = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_q   <= acc && hwrite;
         rd_q   <= acc && !hwrite;
         addr_q <= haddr[7:0];
      end
   end

   logic w_ctrl, w_flags, w_mask, w_cfg, w_pec, w_lim, w_vout;
   assign w_ctrl  = wr_q && addr_q == A_CTRL;
   assign w_flags = wr_q && addr_q == A_FLAGS;
   assign w_mask  = wr_q && addr_q == A_ALERT_MASK;
   assign w_cfg   = wr_q && addr_q == A_FAULT_CFG;
   assign w_pec   = wr_q && addr_q == A_PEC;
   assign w_lim   = wr_q && addr_q == A_LIMITS;
   assign w_vout  = wr_q && addr_q == A_VOUT;

   // Pin synchronisers
   logic [1:0] ctrl_s_q, sync_s_q;
   logic       sync_prev_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_s_q    <= 2'b00;
         sync_s_q    <= 2'b00;
         sync_prev_q <= 1'b0;
      end else begin
         ctrl_s_q    <= {ctrl_s_q[0], ctrl_pin};
         sync_s_q    <= {sync_s_q[0], sync_in};
         sync_prev_q <= sync_s_q[1];
      end
   end

   // Configuration registers, reloaded on watchdog restart
   logic [31:0] ctrl_q, mask_q, cfg_q, lim_q, vout_q;
   logic [1:0]  wd_ph_q;
   logic        reload;
   assign reload = wd_ph_q == 2'd2;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST;
         cfg_q  <= FAULT_CFG_RST;
         lim_q  <= LIMITS_RST;
         vout_q <= VOUT_RST;
      end else if (reload) begin
         ctrl_q <= CTRL_RST;
         mask_q <= MASK_RST;
         cfg_q  <= FAULT_CFG_RST;
         lim_q  <= LIMITS_RST;
         vout_q <= VOUT_RST;
      end else begin
         if (w_ctrl) ctrl_q <= hwdata;
         if (w_mask) mask_q <= hwdata;
         if (w_cfg)  cfg_q  <= hwdata;
         if (w_lim)  lim_q  <= hwdata;
         if (w_vout) vout_q <= hwdata;
      end
   end

   cfam_sync_t sync_mode;
   cfam_src_t  en_src;
   logic [7:0] dtf, dtr;
   logic [2:0] retry_lim;
   logic       resync_cmd, wd_kick;
   assign sync_mode  = cfam_sync_t'(ctrl_q[CTRL_SYNC_LSB +: 2]);
   assign en_src     = cfam_src_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
   assign resync_cmd = w_ctrl && hwdata[CTRL_RESYNC];
   assign wd_kick    = w_ctrl && hwdata[CTRL_WD_KICK];
   assign dtf        = cfg_q[7:0];
   assign dtr        = cfg_q[15:8];
   assign retry_lim  = cfg_q[CFG_RETRY_LSB +: 3];
   assign vout_mode  = vout_q[7:0];
   assign nominal_off_voltage = vout_q[31:16];

   // Output voltage target follows VOUT_MODE exponent
   logic signed [4:0] vexp;
   assign vexp        = vout_mode[4:0];
   assign vout_target = vexp[4] ? vout_q[23:8] >> (-vexp) : vout_q[23:8] << vexp;

   // Enable source policy
   logic en_req, pin_en, op_en;
   assign pin_en = ctrl_s_q[1];
   assign op_en  = ctrl_q[CTRL_OP_ON];
   assign en_req = en_src == SRC_PIN  ? pin_en :
                   en_src == SRC_CMD  ? op_en :
                   en_src == SRC_BOTH ? pin_en && op_en : 1'b0;

   // Millisecond tick
   logic [$clog2(MS_CYC)-1:0] ms_cnt_q;
   logic                      ms_tick;
   assign ms_tick = ms_cnt_q == ($clog2(MS_CYC))'(MS_CYC - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ms_cnt_q <= '0;
      else ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
   end

   // Current filter and over-current compare
   logic [15:0] ifilt_q;
   logic        oc_det, oc_warn;
   assign oc_det  = iout_sample >= lim_q[11:0];
   assign oc_warn = ifilt_q[15:4] >= lim_q[27:16];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) ifilt_q <= 16'h0000;
      else ifilt_q <= ifilt_q - (ifilt_q >> 4) + {4'h0, iout_sample};
   end

   // Per-fault delay qualifiers
   logic [NFAULT-1:0] det, conf;
   assign det = {oc_det, fault_in};
   genvar gi;
   generate
      for (gi = 0; gi < NFAULT; gi++) begin : g_ft
         cfam_fault_timer u_ft (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .ms_tick   (ms_tick),
            .detect    (det[gi]),
            .delay_ms  (dtf),
            .confirmed (conf[gi])
         );
      end
   endgenerate

   // Fault response and retry state machine
   cfam_state_t st_q, st_d;
   logic [2:0]  used_q, used_d;
   logic [14:0] rcnt_q, rcnt_d, rload;
   logic        ot_q, ot_d;
   logic        any_conf, may_retry, rdone;
   assign any_conf  = |conf;
   assign may_retry = retry_lim == RETRY_HICCUP || used_q < retry_lim;
   assign rload     = dtf != 8'h00 ? 15'(dtf * RETRY_SCALE) : {7'h00, dtr};
   assign rdone     = rcnt_q == 15'h0000;

   always_comb begin
      st_d   = st_q;
      used_d = used_q;
      rcnt_d = (ms_tick && !rdone) ? rcnt_q - 15'h0001 : rcnt_q;
      ot_d   = ot_q;
      case (st_q)
         ST_OFF: begin
            if (en_req) begin
               st_d   = ST_RUN;
               used_d = 3'h0;
            end
         end
         ST_RUN: begin
            if (!en_req) st_d = ST_OFF;
            else if (any_conf) begin
               ot_d   = conf[FAULT_OT];
               st_d   = may_retry ? ST_WAIT : ST_LATCH;
               rcnt_d = rload;
            end
         end
         ST_WAIT: begin
            if (!en_req) st_d = ST_OFF;
            else if (rdone) begin
               used_d = retry_lim == RETRY_HICCUP ? used_q : used_q + 3'h1;
               if (!any_conf) st_d = ST_RUN;
               else begin
                  ot_d   = conf[FAULT_OT];
                  st_d   = (retry_lim == RETRY_HICCUP || used_q + 3'h1 < retry_lim) ?
                           ST_WAIT : ST_LATCH;
                  rcnt_d = rload;
               end
            end
         end
         ST_LATCH: begin
            if (!en_req) st_d = ST_OFF;
         end
         default: st_d = ST_OFF;
      endcase
      if (wd_ph_q != 2'd0) st_d = ST_OFF;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q   <= ST_OFF;
         used_q <= 3'h0;
         rcnt_q <= 15'h0000;
         ot_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         used_q <= used_d;
         rcnt_q <= rcnt_d;
         ot_q   <= ot_d;
      end
   end

   logic resp;
   assign resp      = st_q == ST_WAIT || st_q == ST_LATCH;
   assign soft_off  = resp && ot_q;
   assign hiz       = resp && !ot_q;
   assign output_en = st_q == ST_RUN;

   // Watchdog: shutdown, then reload, then restart
   logic [$clog2(WD_CYC)-1:0] wd_cnt_q;
   logic                      wd_fire;
   assign wd_fire   = wd_cnt_q == ($clog2(WD_CYC))'(WD_CYC - 1);
   assign mcu_reset = wd_ph_q != 2'd0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_cnt_q <= '0;
         wd_ph_q  <= 2'd0;
      end else begin
         wd_cnt_q <= (wd_kick || wd_fire) ? '0 : wd_cnt_q + 1'b1;
         wd_ph_q  <= wd_fire ? 2'd1 : wd_ph_q == 2'd0 ? 2'd0 : wd_ph_q + 2'd1;
      end
   end

   // Sync lock window and lock state
   logic        en_prev_q, win_q, lock_q, sync_rise;
   logic [$clog2(MS_CYC+1)-1:0] win_cnt_q;
   logic        win_open;
   assign sync_rise = sync_s_q[1] && !sync_prev_q;
   assign win_open  = en_req && !en_prev_q || resync_cmd;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_prev_q <= 1'b0;
         win_q     <= 1'b0;
         win_cnt_q <= '0;
         lock_q    <= 1'b0;
      end else begin
         en_prev_q <= en_req;
         if (win_open) begin
            win_q     <= 1'b1;
            win_cnt_q <= ($clog2(MS_CYC+1))'(MS_CYC);
            lock_q    <= 1'b0;
         end else if (win_q) begin
            win_cnt_q <= win_cnt_q - 1'b1;
            win_q     <= win_cnt_q != 1;
            if (sync_mode == SYNC_IN && sync_rise) lock_q <= 1'b1;
         end
         if (sync_mode != SYNC_IN) lock_q <= 1'b0;
      end
   end

   // Internal switching clock and frequency measurement
   logic [$clog2(SYNC_DIV+1)-1:0] div_q;
   logic        osc_q, osc_rise;
   logic [11:0] edge_cnt_q, freq_q;
   assign osc_rise = div_q == '0 && !osc_q;
   assign sync_out = osc_q;
   assign sync_oe  = sync_mode == SYNC_OUT;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q      <= '0;
         osc_q      <= 1'b0;
         edge_cnt_q <= 12'h000;
         freq_q     <= 12'h000;
      end else begin
         div_q <= div_q == ($clog2(SYNC_DIV+1))'(SYNC_DIV - 1) ? '0 : div_q + 1'b1;
         if (div_q == '0) osc_q <= !osc_q;
         if (ms_tick) begin
            freq_q     <= edge_cnt_q;
            edge_cnt_q <= 12'h000;
         end else if (lock_q ? sync_rise : osc_rise) edge_cnt_q <= edge_cnt_q + 12'h001;
      end
   end

   // Sticky fault and warning flags, set wins over clear
   logic [7:0] flags_q, flag_set;
   assign flag_set = {warn_in[3:1], oc_warn, conf};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) flags_q <= 8'h00;
      else flags_q <= flag_set | (flags_q & ~(w_flags ? hwdata[7:0] : 8'h00));
   end
   assign alert_out_pin    = 1'b0;
   assign alert_out_pin_oe = |(flags_q & ~mask_q[7:0]);

   // Packet error code, CRC-8 over written bytes
   logic [7:0] pec_q, pec_nx;
   always_comb begin
      pec_nx = pec_q ^ hwdata[7:0];
      for (int i = 0; i < 8; i++) begin
         pec_nx = pec_nx[7] ? {pec_nx[6:0], 1'b0} ^ PEC_POLY : {pec_nx[6:0], 1'b0};
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pec_q <= 8'h00;
      else if (w_pec) pec_q <= hwdata[PEC_CLEAR] ? 8'h00 : pec_nx;
   end

   // Read data mux, LINEAR words with zero exponent
   logic [31:0] status_w;
   assign status_w = {23'h0, win_q, used_q, st_q == ST_LATCH, hiz, soft_off, lock_q, output_en};
   always_comb begin
      hrdata = 32'h0000_0000;
      if (rd_q) begin
         case (addr_q)
            A_CTRL:       hrdata = ctrl_q;
            A_STATUS:     hrdata = status_w;
            A_FLAGS:      hrdata = {24'h0, flags_q};
            A_ALERT_MASK: hrdata = mask_q;
            A_FAULT_CFG:  hrdata = cfg_q;
            A_READ_IOUT:  hrdata = {21'h0, ifilt_q[15:5]};
            A_READ_FREQ:  hrdata = {21'h0, freq_q[10:0]};
            A_READ_TEMP2: hrdata = {21'h0, die_temp[10:0]};
            A_PEC:        hrdata = {24'h0, pec_q};
            A_LIMITS:     hrdata = lim_q;
            A_VOUT:       hrdata = vout_q;
            default:      hrdata = 32'h0000_0000;
         endcase
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_LOCK_WIN: assert property ($rose(lock_q) |-> $past(win_q))
      else $error("Lock outside window");
   AST_RESYNC: assert property (resync_cmd && !reload |=> win_q)
      else $error("Resync did not open window");
   AST_SYNC_DIR: assert property (sync_oe |-> sync_mode == SYNC_OUT)
      else $error("Sync driven while not output");
   AST_FAULT_ACT: assert property (
      st_q == ST_RUN && en_req && any_conf && wd_ph_q == 2'd0 |=> resp)
      else $error("Fault gave no response");
   AST_OT_SOFT: assert property (
      st_q == ST_RUN && en_req && conf[FAULT_OT] && wd_ph_q == 2'd0 |=> soft_off && !hiz)
      else $error("Over-temperature not soft-off");
   AST_HIZ: assert property (
      st_q == ST_RUN && en_req && any_conf && !conf[FAULT_OT] && wd_ph_q == 2'd0
      |=> hiz && !soft_off)
      else $error("Fault not high-impedance");
   AST_RETRY_SCALE: assert property (
      st_q == ST_RUN && st_d == ST_WAIT && dtf != 8'h00
      |=> rcnt_q == 15'($past(dtf) * RETRY_SCALE))
      else $error("Retry delay not scaled");
   AST_HICCUP: assert property (
      st_q == ST_LATCH |-> $past(retry_lim) != RETRY_HICCUP || $past(st_q) == ST_LATCH)
      else $error("Latched off in hiccup mode");
   AST_WD: assert property (wd_fire |=> mcu_reset ##1 !output_en ##1 ctrl_q == CTRL_RST)
      else $error("Watchdog sequence wrong");
   AST_ALERT: assert property ((flag_set & ~mask_q[7:0]) != 8'h00 && !w_mask
      |=> alert_out_pin_oe && !alert_out_pin)
      else $error("Alert not asserted");
   AST_PIN_EN: assert property (en_src == SRC_PIN && !pin_en |=> !output_en)
      else $error("Output on without pin");
   AST_STICKY: assert property (flags_q[0] && !w_flags |=> flags_q[0])
      else $error("Flag lost without clear");
   AST_RETRY_CLR: assert property (st_q == ST_OFF && st_d == ST_RUN |=> used_q == 3'h0)
      else $error("Retry count not cleared");
endmodule // cfam_top

/* testbench/cfam_sync_src.sv */
// Far-side sync clock source model for the converter manager bench
`timescale 1ns/100ps
module cfam_sync_src (
   input  wire logic run,
   output logic      clk_out
);
   // Toggles every 160 ns only while asked to run, and stands low otherwise
   initial clk_out = 1'b0;
   always begin
      #160;
      clk_out = run ? ~clk_out : 1'b0;
   end
endmodule // cfam_sync_src

/* testbench/tb.sv */
// Self-checking bench of the converter fault and alert manager
`timescale 1ns/100ps
module tb;
   import cfam_pkg::*;
   localparam logic [31:0] ONE  = 32'h0000_0001;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   logic        hclk, hresetn, hsel, hwrite, ctrl_pin, sync_run, sync_clk;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, fault_in;
   logic        hreadyout, hresp, sync_out, sync_oe, alert_pin, alert_oe;
   logic [11:0] iout_sample, die_temp;
   logic [3:0]  warn_in;
   logic        output_en, soft_off, hiz, mcu_reset;
   logic [15:0] off_v, vout_target;
   logic [7:0]  vout_mode, e;
   int          error_cnt, check_count, cyc;
   wire         alert_line = alert_oe ? alert_pin : 1'b1;
   wire         sync_line  = sync_oe ? sync_out : sync_clk;

   cfam_sync_src i_cfam_sync_src (.run(sync_run), .clk_out(sync_clk));
   cfam_top #(.MS_CYC(50), .WD_CYC(30000)) i_cfam_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctrl_pin(ctrl_pin),
      .sync_in(sync_line), .sync_out(sync_out), .sync_oe(sync_oe),
      .alert_out_pin(alert_pin), .alert_out_pin_oe(alert_oe),
      .iout_sample(iout_sample), .die_temp(die_temp), .fault_in(fault_in),
      .warn_in(warn_in), .output_en(output_en), .soft_off(soft_off), .hiz(hiz),
      .nominal_off_voltage(off_v), .vout_target(vout_target),
      .vout_mode(vout_mode), .mcu_reset(mcu_reset));

   initial hclk = 1'b0;
   always #20 hclk = ~hclk;

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One single transfer; waits on hready in both phases
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      ahb(1'b0, a, ZERO);
      chk(rd & m, exp);
   endtask

   task automatic wt(ref logic s, input logic v);
      for (int i = 0; i < 400 && s !== v; i++) @(posedge hclk);
      chk(32'(s), 32'(v));
   endtask

   // Drops faults, leaves latch-off through the pin and clears every flag
   task automatic recover;
      fault_in <= 3'b000;
      warn_in  <= 4'b0000;
      ctrl_pin <= 1'b0;
      ahb(1'b1, A_FLAGS, 32'h0000_00FF);
      wt(alert_oe, 1'b0);
      ctrl_pin <= 1'b1;
      wt(output_en, 1'b1);
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] x;
      x = c ^ b;
      for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ PEC_POLY : {x[6:0], 1'b0};
      return x;
   endfunction

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         summarize();
      end
   end

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, ctrl_pin, sync_run, fault_in, warn_in} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'b010;
      iout_sample = 12'h100;
      die_temp = 12'h1A3;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdc(A_CTRL, 32'hFFFF_FFFF, CTRL_RST);
      chk(32'(sync_oe), ZERO);
      rdc(A_LIMITS, 32'hFFFF_FFFF, LIMITS_RST);
      rdc(A_VOUT, 32'hFFFF_FFFF, VOUT_RST);
      chk(32'(vout_mode), VOUT_RST & 32'h0000_00FF);
      chk(32'({hresp, hreadyout}), ONE);
      ahb(1'b1, A_VOUT, 32'h0012_341F);
      @(posedge hclk);
      chk(32'(vout_target), 32'h0000_091A);
      chk(32'(off_v), 32'h0000_0012);
      rdc(A_READ_TEMP2, 32'hFFFF_FFFF, 32'h0000_01A3);
      rdc(8'h40, 32'hFFFF_FFFF, ZERO);
      $display("test reset done");
      ahb(1'b1, A_CTRL, 32'h0000_0001);
      repeat (8) @(posedge hclk);
      chk(32'(output_en), ZERO);
      ahb(1'b1, A_CTRL, 32'h0000_0003);
      wt(output_en, 1'b1);
      ahb(1'b1, A_CTRL, 32'h0000_0005);
      wt(output_en, 1'b0);
      ctrl_pin <= 1'b1;
      wt(output_en, 1'b1);
      ahb(1'b1, A_CTRL, 32'h0000_0004);
      wt(output_en, 1'b0);
      ahb(1'b1, A_CTRL, ZERO);
      wt(output_en, 1'b1);
      $display("test enable done");
      sync_run <= 1'b1;
      ctrl_pin <= 1'b0;
      ahb(1'b1, A_CTRL, 32'h0000_0010);
      wt(output_en, 1'b0);
      ctrl_pin <= 1'b1;
      repeat (30) @(posedge hclk);
      rdc(A_STATUS, 32'h0000_0102, 32'h0000_0102);
      repeat (60) @(posedge hclk);
      rdc(A_STATUS, 32'h0000_0100, ZERO);
      ahb(1'b1, A_CTRL, 32'h0000_0018);
      rdc(A_STATUS, 32'h0000_0100, 32'h0000_0100);
      sync_run <= 1'b0;
      ahb(1'b1, A_CTRL, 32'h0000_0020);
      wt(sync_oe, 1'b1);
      ahb(1'b1, A_CTRL, ZERO);
      wt(sync_oe, 1'b0);
      $display("test sync done");
      fault_in <= 3'b001;
      wt(soft_off, 1'b1);
      chk(32'(hiz), ZERO);
      wt(alert_oe, 1'b1);
      chk(32'(alert_line), ZERO);
      fault_in <= 3'b000;
      repeat (4) @(posedge hclk);
      rdc(A_FLAGS, 32'h0000_000F, ONE);
      recover();
      iout_sample <= 12'hFFF;
      @(posedge hclk);
      iout_sample <= 12'h100;
      wt(hiz, 1'b1);
      chk(32'(soft_off), ZERO);
      rdc(A_FLAGS, 32'h0000_000F, 32'h0000_0008);
      recover();
      warn_in <= 4'b0010;
      wt(alert_oe, 1'b1);
      chk(32'(output_en), ONE);
      rdc(A_FLAGS, 32'h0000_00FF, 32'h0000_0020);
      ahb(1'b1, A_ALERT_MASK, 32'h0000_0020);
      recover();
      warn_in <= 4'b0010;
      repeat (8) @(posedge hclk);
      chk(32'(alert_oe), ZERO);
      rdc(A_FLAGS, 32'h0000_0020, 32'h0000_0020);
      ahb(1'b1, A_ALERT_MASK, ZERO);
      recover();
      $display("test fault done");
      ahb(1'b1, A_FAULT_CFG, 32'h0000_0002);
      fault_in <= 3'b010;
      repeat (40) @(posedge hclk);
      fault_in <= 3'b000;
      repeat (150) @(posedge hclk);
      chk(32'(hiz), ZERO);
      rdc(A_FLAGS, 32'h0000_000F, ZERO);
      ahb(1'b1, A_FAULT_CFG, 32'h0001_0001);
      fault_in <= 3'b010;
      wt(hiz, 1'b1);
      repeat (4000) @(posedge hclk);
      rdc(A_STATUS, 32'h0000_0010, ZERO);
      repeat (2200) @(posedge hclk);
      rdc(A_STATUS, 32'h0000_00F0, 32'h0000_0030);
      recover();
      rdc(A_STATUS, 32'h0000_00E0, ZERO);
      $display("test retry done");
      ahb(1'b1, A_PEC, 32'h0000_0100);
      ahb(1'b1, A_PEC, 32'h0000_0031);
      ahb(1'b1, A_PEC, 32'h0000_0052);
      e = crc8(crc8(8'h00, 8'h31), 8'h52);
      rdc(A_PEC, 32'h0000_00FF, {24'h00_0000, e});
      rdc(A_READ_IOUT, 32'hFFFF_FFFF, 32'h0000_0080);
      $display("test pec done");
      ahb(1'b1, A_CTRL, 32'h0000_0020);
      for (int i = 0; i < 32000 && mcu_reset !== 1'b1; i++) @(posedge hclk);
      chk(32'(mcu_reset), ONE);
      @(posedge hclk);
      chk(32'(output_en), ZERO);
      repeat (4) @(posedge hclk);
      rdc(A_CTRL, 32'hFFFF_FFFF, CTRL_RST);
      rdc(A_VOUT, 32'hFFFF_FFFF, VOUT_RST);
      rdc(A_FAULT_CFG, 32'hFFFF_FFFF, FAULT_CFG_RST);
      $display("test watchdog done");
      summarize();
   end
endmodule // tb
